// ===== pchr_pkg.sv
package pchr_pkg;

// ==========================================================
// configuration dword indices (byte address = 4 * index)
// ==========================================================
localparam int unsigned PCHR_IDX_W = 6;
localparam logic [5:0] PCHR_IDX_REV_CLASS = 6'h02;
localparam logic [5:0] PCHR_IDX_CLS_LAT_HDR = 6'h03;
localparam logic [5:0] PCHR_IDX_BAR0 = 6'h04;
localparam logic [5:0] PCHR_IDX_BAR1 = 6'h05;
localparam logic [5:0] PCHR_IDX_BAR2 = 6'h06;
localparam logic [5:0] PCHR_IDX_SUBSYS = 6'h0B;

// ==========================================================
// field positions inside the dwords
// ==========================================================
localparam int unsigned PCHR_REV_LSB = 0;
localparam int unsigned PCHR_CLASS_LSB = 8;
localparam int unsigned PCHR_CLS_LSB = 0;
localparam int unsigned PCHR_LAT_LSB = 8;
localparam int unsigned PCHR_HDR_LSB = 16;
localparam int unsigned PCHR_SUB_VENDOR_LSB = 0;
localparam int unsigned PCHR_SUB_ID_LSB = 16;
localparam int unsigned PCHR_BAR0_BASE_LSB = 22;
localparam int unsigned PCHR_BAR1_BASE_LSB = 23;
localparam int unsigned PCHR_BAR2_BASE_LSB = 4;

// ==========================================================
// fixed and reset values
// ==========================================================
localparam logic [23:0] PCHR_CLASS_VALUE = 24'h000000;
localparam logic [7:0] PCHR_HDR_VALUE = 8'h00;
localparam logic [7:0] PCHR_CLS_RST = 8'h00;
localparam logic [7:0] PCHR_CLS_MAX = 8'h80;
localparam logic [7:0] PCHR_LAT_RST = 8'h00;
localparam logic [3:0] PCHR_BAR0_LOW = 4'h8;
localparam logic [3:0] PCHR_BAR1_LOW = 4'h0;
localparam logic [3:0] PCHR_BAR2_LOW = 4'h1;
localparam logic [31:0] PCHR_BAR0_RST = 32'h00000000;
localparam logic [31:0] PCHR_BAR1_RST = 32'h00000000;
localparam logic [31:0] PCHR_BAR2_RST = 32'h00000010;
localparam logic [15:0] PCHR_SUB_RST = 16'h0000;
localparam logic [31:0] PCHR_ALL_ONES = 32'hFFFFFFFF;

// ==========================================================
// carriers
// ==========================================================
typedef struct packed {
    logic we;
    logic [5:0] idx;
    logic [3:0] byte_en;
    logic [31:0] wdata;
} pchr_cfg_req_s;

typedef struct packed {
    logic [15:0] board_id;
    logic [15:0] vendor_id;
} pchr_sub_ids_s;

endpackage

// ===== pchr_bar_reg.sv
`timescale 1ns/1ns
`default_nettype none
module pchr_bar_reg
    import pchr_pkg::*;
#(
    parameter int unsigned BASE_LSB = 22,
    parameter logic [3:0] LOW_BITS = 4'h0,
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [3:0] i_byte_en,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_value
);

    // ==========================================================
    // size mask: only the base field from bit BASE_LSB upward is stored
    // ==========================================================
    localparam logic [31:0] BASE_MASK = PCHR_ALL_ONES << BASE_LSB;

    // the low nibble carries fixed type bits, so the base field cannot reach into it
    if (BASE_LSB < 4 || BASE_LSB > 31) begin : g_bad_base_lsb
        $error("BASE_LSB must lie in 4..31");
    end

    logic [31:0] base_ff;
    logic [31:0] nxt_base;

    always_comb begin
        nxt_base = base_ff;
        for (int b = 0; b < 4; b++) begin
            if (i_byte_en[b]) begin
                nxt_base[b*8 +: 8] = i_wdata[b*8 +: 8];
            end
        end
        nxt_base = nxt_base & BASE_MASK;
    end

    // writes below the base field vanish, so the host reads the size mask
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            base_ff <= RESET_VALUE & BASE_MASK;
        end else if (i_wr) begin
            base_ff <= nxt_base;
        end
    end

    assign o_value = base_ff | {28'h0000000, LOW_BITS};

endmodule
`default_nettype wire

// ===== pchr_sub_ids.sv
`timescale 1ns/1ns
`default_nettype none
module pchr_sub_ids
    import pchr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire pchr_sub_ids_s i_ids,
    output pchr_sub_ids_s o_ids
);

    // ==========================================================
    // board identifiers, loadable only by autoinitialization
    // ==========================================================
    pchr_sub_ids_s ids_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ids_ff.board_id <= PCHR_SUB_RST;
            ids_ff.vendor_id <= PCHR_SUB_RST;
        end else if (i_load) begin
            ids_ff <= i_ids;
        end
    end

    assign o_ids = ids_ff;

endmodule
`default_nettype wire

// ===== pchr_cfg_header.sv
// Functional notes
// - class code reads zero, 24 bits
// - cache line size keeps powers of two
// - header type reads zero
// - first window reads FFC00008 when sized
// - first window base bits 31..22 writable
// - first window bits 21..4 read zero
// - first window bit 3 reads one
// - memory windows bits 2..0 read zero
// - second window reads FF800000 when sized
// - second window base bits 31..23 writable
// - second window bits 22..3 read zero
// - third window reads FFFFFFF1 when sized
// - third window base bits 31..4 writable
// - third window bits 3..2 read zero
// - third window bit1 zero, bit0 one
// - read-only sixteen bit board identifier
// - read-only sixteen bit board vendor identifier
// - identifiers reset zero unless eeprom loaded
`timescale 1ns/1ns
`default_nettype none
module pchr_cfg_header
    import pchr_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = 8'h01
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cfg_req,
    input wire pchr_cfg_req_s i_cfg,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    input wire logic i_eeprom_load,
    input wire pchr_sub_ids_s i_eeprom_ids,
    output logic [7:0] o_cache_line_size,
    output logic [7:0] o_latency_timer,
    output logic [31:0] o_prefetch_mem_window_base,
    output logic [31:0] o_plain_mem_window_base,
    output logic [31:0] o_io_window_base,
    output pchr_sub_ids_s o_board_ids
);

    // silicon revision value is arbitrary

    // ==========================================================
    // request decode
    // ==========================================================
    logic wr_req;
    logic rd_req;
    logic hit_cls_lat;
    logic wr_bar0;
    logic wr_bar1;
    logic wr_bar2;

    assign wr_req = i_cfg_req && i_cfg.we;
    assign rd_req = i_cfg_req && !i_cfg.we;
    assign hit_cls_lat = wr_req && (i_cfg.idx == PCHR_IDX_CLS_LAT_HDR);
    assign wr_bar0 = wr_req && (i_cfg.idx == PCHR_IDX_BAR0);
    assign wr_bar1 = wr_req && (i_cfg.idx == PCHR_IDX_BAR1);
    assign wr_bar2 = wr_req && (i_cfg.idx == PCHR_IDX_BAR2);

    // ==========================================================
    // cache line size and latency timer
    // ==========================================================
    logic [7:0] cls_ff;
    logic [7:0] lat_ff;
    logic [7:0] cls_wr_val;
    logic cls_legal;

    assign cls_wr_val = i_cfg.wdata[PCHR_CLS_LSB +: 8];
    // zero passes the power-of-two test, which is what we want
    assign cls_legal = ((cls_wr_val & (cls_wr_val - 8'h01)) == 8'h00) && (cls_wr_val <= PCHR_CLS_MAX);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cls_ff <= PCHR_CLS_RST;
        end else if (hit_cls_lat && i_cfg.byte_en[0]) begin
            cls_ff <= cls_legal ? cls_wr_val : 8'h00;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lat_ff <= PCHR_LAT_RST;
        end else if (hit_cls_lat && i_cfg.byte_en[1]) begin
            lat_ff <= i_cfg.wdata[PCHR_LAT_LSB +: 8];
        end
    end

    // ==========================================================
    // base address windows
    // ==========================================================
    logic [31:0] bar0_val;
    logic [31:0] bar1_val;
    logic [31:0] bar2_val;

    pchr_bar_reg #(
        .BASE_LSB(PCHR_BAR0_BASE_LSB),
        .LOW_BITS(PCHR_BAR0_LOW),
        .RESET_VALUE(PCHR_BAR0_RST)
    ) u_bar0 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_bar0),
        .i_byte_en(i_cfg.byte_en),
        .i_wdata(i_cfg.wdata),
        .o_value(bar0_val)
    );

    pchr_bar_reg #(
        .BASE_LSB(PCHR_BAR1_BASE_LSB),
        .LOW_BITS(PCHR_BAR1_LOW),
        .RESET_VALUE(PCHR_BAR1_RST)
    ) u_bar1 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_bar1),
        .i_byte_en(i_cfg.byte_en),
        .i_wdata(i_cfg.wdata),
        .o_value(bar1_val)
    );

    pchr_bar_reg #(
        .BASE_LSB(PCHR_BAR2_BASE_LSB),
        .LOW_BITS(PCHR_BAR2_LOW),
        .RESET_VALUE(PCHR_BAR2_RST)
    ) u_bar2 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_bar2),
        .i_byte_en(i_cfg.byte_en),
        .i_wdata(i_cfg.wdata),
        .o_value(bar2_val)
    );

    // ==========================================================
    // board identifiers
    // ==========================================================
    pchr_sub_ids_s ids_val;

    pchr_sub_ids u_ids (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(i_eeprom_load),
        .i_ids(i_eeprom_ids),
        .o_ids(ids_val)
    );

    // ==========================================================
    // read multiplexer
    // ==========================================================
    logic [31:0] nxt_rdata;

    // unmapped indices read zero so a scan of the header sees empty dwords
    always_comb begin
        nxt_rdata = 32'h00000000;
        unique case (i_cfg.idx)
            PCHR_IDX_REV_CLASS: begin
                nxt_rdata[PCHR_REV_LSB +: 8] = SILICON_REVISION;
                nxt_rdata[PCHR_CLASS_LSB +: 24] = PCHR_CLASS_VALUE;
            end
            PCHR_IDX_CLS_LAT_HDR: begin
                nxt_rdata[PCHR_CLS_LSB +: 8] = cls_ff;
                nxt_rdata[PCHR_LAT_LSB +: 8] = lat_ff;
                nxt_rdata[PCHR_HDR_LSB +: 8] = PCHR_HDR_VALUE;
            end
            PCHR_IDX_BAR0: begin
                nxt_rdata = bar0_val;
            end
            PCHR_IDX_BAR1: begin
                nxt_rdata = bar1_val;
            end
            PCHR_IDX_BAR2: begin
                nxt_rdata = bar2_val;
            end
            PCHR_IDX_SUBSYS: begin
                nxt_rdata[PCHR_SUB_VENDOR_LSB +: 16] = ids_val.vendor_id;
                nxt_rdata[PCHR_SUB_ID_LSB +: 16] = ids_val.board_id;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    // ==========================================================
    // answer path: one cycle after every request
    // ==========================================================
    logic ack_ff;
    logic [31:0] rdata_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= i_cfg_req;
        end
    end

    // writes answer with zero data; read-only fields simply have no store
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_req) begin
            rdata_ff <= nxt_rdata;
        end else if (wr_req) begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign o_cfg_ack = ack_ff;
    assign o_cfg_rdata = rdata_ff;

    // ==========================================================
    // registered copies for the target logic
    // ==========================================================
    assign o_cache_line_size = cls_ff;
    assign o_latency_timer = lat_ff;
    assign o_prefetch_mem_window_base = bar0_val;
    assign o_plain_mem_window_base = bar1_val;
    assign o_io_window_base = bar2_val;
    assign o_board_ids = ids_val;

    // ==========================================================
    // checks
    // ==========================================================
    a_class_reads_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        rd_req && (i_cfg.idx == PCHR_IDX_REV_CLASS)
        |=> o_cfg_ack && (o_cfg_rdata[31:8] == 24'h000000)
    ) else $error("class code not zero");

    a_cls_illegal_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_cls_lat && i_cfg.byte_en[0] && !cls_legal |=> (cls_ff == 8'h00)
    ) else $error("illegal cache line size stored");

    a_cls_legal_kept: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_cls_lat && i_cfg.byte_en[0] && (cls_wr_val == 8'h40) |=> (cls_ff == 8'h40)
    ) else $error("legal cache line size lost");

    a_hdr_reads_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        rd_req && (i_cfg.idx == PCHR_IDX_CLS_LAT_HDR)
        |=> (o_cfg_rdata[23:16] == 8'h00) && (o_cfg_rdata[7:0] == $past(cls_ff))
    ) else $error("header type not zero");

    a_bar0_sizing: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_bar0 && (i_cfg.byte_en == 4'hF) && (i_cfg.wdata == PCHR_ALL_ONES)
        |=> (bar0_val == 32'hFFC00008)
    ) else $error("first window size mask wrong");

    a_bar0_base_kept: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_bar0 && (i_cfg.byte_en == 4'hF)
        |=> (bar0_val[31:22] == $past(i_cfg.wdata[31:22])) ##1 ($stable(bar0_val) || $past(wr_bar0))
    ) else $error("first window base not kept");

    a_bar0_low_fixed: assert property (
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |-> (bar0_val[21:0] == 22'h000008)
    ) else $error("first window low bits wrong");

    a_bar1_sizing: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_bar1 && (i_cfg.byte_en == 4'hF) && (i_cfg.wdata == PCHR_ALL_ONES)
        |=> (bar1_val == 32'hFF800000) ##1 ((bar1_val == 32'hFF800000) || $past(wr_bar1))
    ) else $error("second window size mask wrong");

    a_bar1_base_kept: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_bar1 && (i_cfg.byte_en == 4'hF)
        |=> (bar1_val == {$past(i_cfg.wdata[31:23]), 23'h000000})
    ) else $error("second window base wrong");

    a_bar2_sizing: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_bar2 && (i_cfg.byte_en == 4'hF) && (i_cfg.wdata == PCHR_ALL_ONES)
        |=> (bar2_val == 32'hFFFFFFF1)
    ) else $error("io window size mask wrong");

    a_bar2_base_kept: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_bar2 && (i_cfg.byte_en == 4'hF)
        |=> (bar2_val == {$past(i_cfg.wdata[31:4]), 4'h1})
    ) else $error("io window base wrong");

    a_bar1_low_fixed: assert property (
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |-> (bar1_val[22:0] == 23'h000000)
    ) else $error("second window low bits wrong");

    a_bar2_low_fixed: assert property (
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |-> (bar2_val[3:0] == 4'h1)
    ) else $error("io window low bits wrong");

    a_lat_kept: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_cls_lat && i_cfg.byte_en[1] |=> (lat_ff == $past(i_cfg.wdata[PCHR_LAT_LSB +: 8]))
    ) else $error("latency timer write lost");

    a_ids_read_back: assert property (
        @(posedge i_clk) disable iff (i_rst)
        rd_req && (i_cfg.idx == PCHR_IDX_SUBSYS)
        |=> (o_cfg_rdata == {$past(ids_val.board_id), $past(ids_val.vendor_id)})
    ) else $error("board identifiers misread");

    a_ids_hold: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_eeprom_load |=> $stable(ids_val)
    ) else $error("identifiers changed without load");

    a_ids_load: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_eeprom_load |=> (ids_val == $past(i_eeprom_ids))
    ) else $error("identifier load lost");

    a_ro_write_ignored: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_req && (i_cfg.idx == PCHR_IDX_SUBSYS) && !i_eeprom_load |=> $stable(ids_val)
    ) else $error("read-only write took effect");

    a_ack_one_cycle: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_cfg_req |=> o_cfg_ack ##1 (!o_cfg_ack || $past(i_cfg_req))
    ) else $error("answer not one cycle after request");

    a_ack_no_spurious: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_cfg_req |=> !o_cfg_ack
    ) else $error("answer without request");

    a_write_reads_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_req |=> o_cfg_ack && (o_cfg_rdata == 32'h00000000)
    ) else $error("write answer carries data");

endmodule
`default_nettype wire

// ===== pchr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pchr_host_model
    import pchr_pkg::*;
(
    input wire logic i_clk,
    output logic o_cfg_req,
    output pchr_cfg_req_s o_cfg,
    input wire logic i_cfg_ack,
    input wire logic [31:0] i_cfg_rdata
);
    // ==========================================================
    // configuring master, one dword per access
    // ==========================================================
    initial begin
        o_cfg_req = 1'b0;
        o_cfg = '0;
    end

    // pulse for one cycle, then a bounded wait for the answer strobe
    task automatic access(input logic we, input logic [5:0] idx, input logic [3:0] be,
                          input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
        ok = 1'b0;
        rdata = 32'h00000000;
        @(negedge i_clk);
        o_cfg_req = 1'b1;
        o_cfg = '{we: we, idx: idx, byte_en: be, wdata: wdata};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge i_clk);
            o_cfg_req = 1'b0;
            // released data must not keep showing the old value
            o_cfg.wdata = ~wdata;
            if (i_cfg_ack === 1'b1) begin
                ok = 1'b1;
                rdata = i_cfg_rdata;
            end
        end
    endtask

    // all ones first, then the readback is the size mask
    task automatic size_window(input logic [5:0] idx, output logic [31:0] mask, output logic ok);
        logic [31:0] dummy;
        logic ok_w;
        access(1'b1, idx, 4'hF, PCHR_ALL_ONES, dummy, ok_w);
        access(1'b0, idx, 4'h0, 32'h00000000, mask, ok);
        ok = ok & ok_w;
    endtask
endmodule
`default_nettype wire

// ===== pchr_cfg_header_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pchr_cfg_header_tb;
    import pchr_pkg::*;
    localparam logic [7:0] REV = 8'h5A;
    logic i_clk = 1'b0;
    logic i_rst;
    logic i_cfg_req;
    pchr_cfg_req_s i_cfg;
    logic o_cfg_ack;
    logic [31:0] o_cfg_rdata;
    logic i_eeprom_load;
    pchr_sub_ids_s i_eeprom_ids;
    logic [7:0] o_cache_line_size;
    logic [7:0] o_latency_timer;
    logic [31:0] o_prefetch_mem_window_base;
    logic [31:0] o_plain_mem_window_base;
    logic [31:0] o_io_window_base;
    pchr_sub_ids_s o_board_ids;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] got;
    logic ok;
    logic [5:0] bar_idx [3] = '{PCHR_IDX_BAR0, PCHR_IDX_BAR1, PCHR_IDX_BAR2};
    logic [31:0] bar_rst [3] = '{32'h00000008, 32'h00000000, 32'h00000011};
    logic [31:0] bar_mask [3] = '{32'hFFC00008, 32'hFF800000, 32'hFFFFFFF1};
    logic [31:0] bar_base [3] = '{32'hA5800008, 32'hA5800000, 32'hA5A5A5A1};
    logic [7:0] cls_vals [13] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                                 8'h03, 8'hFF, 8'h81, 8'h0C};
    // only zero or a power of two up to 80h survives a write
    logic [7:0] cls_want [13] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                                  8'h00, 8'h00, 8'h00, 8'h00};

    pchr_cfg_header #(.SILICON_REVISION(REV)) pchr_cfg_header_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_cfg_req(i_cfg_req), .i_cfg(i_cfg),
        .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata), .i_eeprom_load(i_eeprom_load),
        .i_eeprom_ids(i_eeprom_ids), .o_cache_line_size(o_cache_line_size),
        .o_latency_timer(o_latency_timer), .o_prefetch_mem_window_base(o_prefetch_mem_window_base),
        .o_plain_mem_window_base(o_plain_mem_window_base), .o_io_window_base(o_io_window_base),
        .o_board_ids(o_board_ids)
    );

    pchr_host_model pchr_host_model_inst (
        .i_clk(i_clk), .o_cfg_req(i_cfg_req), .o_cfg(i_cfg),
        .i_cfg_ack(o_cfg_ack), .i_cfg_rdata(o_cfg_rdata)
    );

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic close_out();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic need(input logic k);
        if (k !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t got %h exp %h", $time, k, 1'b1);
            close_out();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] d);
        pchr_host_model_inst.access(1'b1, idx, be, d, got, ok);
        need(ok);
        chk(got, 32'h00000000);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] e);
        pchr_host_model_inst.access(1'b0, idx, 4'h0, 32'h00000000, got, ok);
        need(ok);
        chk(got, e);
    endtask

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        i_rst = 1'b1;
        i_eeprom_load = 1'b0;
        i_eeprom_ids = '0;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        rd(PCHR_IDX_REV_CLASS, {24'h000000, REV});
        wr(PCHR_IDX_REV_CLASS, 4'hF, 32'hFFFFFFFF);
        rd(PCHR_IDX_REV_CLASS, {24'h000000, REV});
        rd(PCHR_IDX_CLS_LAT_HDR, 32'h00000000);
        foreach (cls_vals[k]) begin
            wr(PCHR_IDX_CLS_LAT_HDR, 4'h1, {24'h000000, cls_vals[k]});
            rd(PCHR_IDX_CLS_LAT_HDR, {24'h000000, cls_want[k]});
            chk({24'h000000, o_cache_line_size}, {24'h000000, cls_want[k]});
        end
        wr(PCHR_IDX_CLS_LAT_HDR, 4'hF, 32'hFFFFAB07);
        rd(PCHR_IDX_CLS_LAT_HDR, 32'h0000AB00);
        chk({24'h000000, o_latency_timer}, 32'h000000AB);
        for (int b = 0; b < 3; b++) begin
            rd(bar_idx[b], bar_rst[b]);
            pchr_host_model_inst.size_window(bar_idx[b], got, ok);
            need(ok);
            chk(got, bar_mask[b]);
            wr(bar_idx[b], 4'hF, 32'hA5A5A5A5);
            rd(bar_idx[b], bar_base[b]);
        end
        chk(o_prefetch_mem_window_base, 32'hA5800008);
        chk(o_plain_mem_window_base, 32'hA5800000);
        chk(o_io_window_base, 32'hA5A5A5A1);
        wr(PCHR_IDX_BAR2, 4'h1, 32'h00000000);
        rd(PCHR_IDX_BAR2, 32'hA5A5A501);
        wr(PCHR_IDX_BAR0, 4'h7, 32'h00000000);
        rd(PCHR_IDX_BAR0, 32'hA5000008);
        rd(PCHR_IDX_SUBSYS, 32'h00000000);
        wr(PCHR_IDX_SUBSYS, 4'hF, 32'hFFFFFFFF);
        rd(PCHR_IDX_SUBSYS, 32'h00000000);
        @(negedge i_clk);
        i_eeprom_load = 1'b1;
        i_eeprom_ids = '{board_id: 16'h1234, vendor_id: 16'h5678};
        @(negedge i_clk);
        i_eeprom_load = 1'b0;
        i_eeprom_ids = ~i_eeprom_ids;
        chk(o_board_ids, 32'h12345678);
        rd(PCHR_IDX_SUBSYS, 32'h12345678);
        wr(6'h3F, 4'hF, 32'hFFFFFFFF);
        rd(6'h3F, 32'h00000000);
        // a second reset must bring every stored field back
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        chk({o_latency_timer, o_cache_line_size}, 32'h00000000);
        chk(o_prefetch_mem_window_base, 32'h00000008);
        chk(o_io_window_base, 32'h00000011);
        chk(o_board_ids, 32'h00000000);
        rd(PCHR_IDX_BAR1, 32'h00000000);
        close_out();
    end
endmodule
`default_nettype wire
